// ==== mop_defs.svh ====
`ifndef MOP_DEFS_SVH
`define MOP_DEFS_SVH
// What this block does
// - first rated current 0 to 500 A sets the first channel's full level.
// - first rated current zero stops first channel; transistor protection stays on.
// - second rated current 0 to 500 A; 9999 disables; used only with select high.
// - select high with valid second setting bases protection on second setting.
// - second-function select comes from the input terminal coded 3.
// - each channel heats, cools with zero current, or stays inactive.
// - valid second setting heats the selected channel, cools the other.
// - second setting zero keeps channel two off; channel one cools when selected.
// - second setting 9999 without second motor always heats channel one.
// - either motor accumulator at 85 percent raises prealarm output and indication.
// - accumulator at 100 percent trips with motor or transistor fault code.
// - prealarm alone never trips.
// - prealarm drives output terminals coded 8 high-true or 108 low-true.
// - thermal trip clears only by reset; accumulators also decay to zero while below rating or cooling.
// - external thermal relay input trips with external fault code.
// - external thermal relay input comes from input terminal coded 7.
// - thermistor resistance at threshold 0.5 to 30 kohm trips with thermistor code.
// - threshold 9999 disables thermistor; resistance shown only while enabled.
// - constant-torque curve applies from 6 Hz upward.
// - applied motor codes 1, 13, 50, 53 allow full torque at low speed.
// - higher switching-frequency setting shortens transistor protection time.
// - second rated current and threshold writable only with display select 0.
// - thermistor enabled blocks analog terminal as frequency command.

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MOP_CLK_MHZ 40
`define MOP_TICK_US 1000
`define MOP_TICK_CYCLES (`MOP_TICK_US * `MOP_CLK_MHZ)

// ----------------------------------------------------------------
// settings and limits
// ----------------------------------------------------------------
`define MOP_SET_OFF 16'hffff
`define MOP_SEL_OFF 8'hff
`define MOP_AMP_MAX 16'd50000
`define MOP_PTC_MIN 16'd500
`define MOP_PTC_MAX 16'd30000
`define MOP_INV_RATED 16'd1000
`define MOP_CT_MIN_FREQ 16'd600
`define MOP_STD_DRT_FREQ 16'd3000
`define MOP_ACC_FULL 32'd60000000
`define MOP_PRE_PCT 85
`define MOP_FULL_PCT 100
`define MOP_FN_SECOND 6'd3
`define MOP_FN_OH 6'd7
`define MOP_FN_PRE_POS 7'd8
`define MOP_FN_PRE_NEG 7'd108
`define MOP_CT_A 8'd1
`define MOP_CT_B 8'd13
`define MOP_CT_C 8'd50
`define MOP_CT_D 8'd53

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define MOP_OFF_RATED1 8'h00
`define MOP_OFF_RATED2 8'h04
`define MOP_OFF_PTC 8'h08
`define MOP_OFF_MOTOR 8'h0c
`define MOP_OFF_INSEL 8'h10
`define MOP_OFF_OUTSEL 8'h14
`define MOP_OFF_STATUS 8'h18
`define MOP_OFF_PTCRES 8'h1c
`define MOP_OFF_ACC1 8'h20
`define MOP_OFF_ACC2 8'h24
`define MOP_OFF_ACCT 8'h28
`define MOP_F_APPL 7:0
`define MOP_F_SEC 15:8
`define MOP_F_SWF 19:16
`define MOP_F_DISP 31:24
`define MOP_F_INSEL 29:0
`define MOP_F_OUTSEL 20:0
`define MOP_IN_CODES_RST 30'h00000000
`define MOP_OUT_CODES_RST 21'h000000
`endif

// ==== mop_pkg.sv ====
package mop_pkg;
  typedef enum logic [1:0] {
    MOP_M_OFF  = 2'b00,
    MOP_M_COOL = 2'b01,
    MOP_M_HEAT = 2'b11
  } mop_mode_e;
  typedef enum logic [0:0] {
    MOP_ST_RUN  = 1'b0,
    MOP_ST_TRIP = 1'b1
  } mop_state_e;
  typedef enum logic [3:0] {
    MOP_F_NONE  = 4'h0,
    MOP_F_MOTOR = 4'h1,
    MOP_F_XTR   = 4'h2,
    MOP_F_EXT   = 4'h3,
    MOP_F_PTC   = 4'h4
  } mop_fault_e;
endpackage

// ==== mop_thermal_acc.sv ====
`timescale 1ns/1ps
`include "mop_defs.svh"
module mop_thermal_acc (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  // control
  input  wire logic             tick,
  input  mop_pkg::mop_mode_e    mode,
  input  wire logic [15:0]      current,
  input  wire logic [15:0]      rated,
  input  wire logic [3:0]       gain_sh,
  input  wire logic             derate,
  // state
  output logic      [31:0]      acc_reg,
  output logic                  pre,
  output logic                  full
);
  import mop_pkg::*;
  localparam logic [31:0] FULL = `MOP_ACC_FULL;
  localparam logic [31:0] PRE  = 32'(64'(`MOP_ACC_FULL) * `MOP_PRE_PCT / `MOP_FULL_PCT);
  logic [15:0] eff;
  logic [15:0] amps;
  logic [15:0] excess;
  logic [32:0] sum;
  logic [31:0] acc_next;

  // low speed derating trims the rating by a quarter
  always_comb begin
    eff    = derate ? rated - (rated >> 2) : rated;
    amps   = (mode == MOP_M_HEAT) ? current : 16'h0000;
    excess = (amps > eff) ? amps - eff : 16'h0000;
    sum    = {1'b0, acc_reg} + (33'(excess) << gain_sh);
    if (excess != 16'h0000) begin
      acc_next = (sum > {1'b0, FULL}) ? FULL : sum[31:0];
    end else begin
      acc_next = acc_reg - ((acc_reg >> 8) + 32'(acc_reg != 32'h0));
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_reg <= 32'h0;
    end else if (tick) begin
      unique case (mode)
        MOP_M_HEAT, MOP_M_COOL: acc_reg <= acc_next;
        MOP_M_OFF:              acc_reg <= acc_reg;
        default:                acc_reg <= acc_reg;
      endcase
    end
  end

  assign pre  = acc_reg >= PRE;
  assign full = acc_reg >= FULL;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_off_hold;
    mode == MOP_M_OFF |=> $stable(acc_reg);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("inactive channel moved");
  property p_cool_decay;
    tick && mode == MOP_M_COOL |=> acc_reg <= $past(acc_reg);
  endproperty
  a_cool_decay: assert property (p_cool_decay) else $error("cooling grew");
endmodule // mop_thermal_acc

// ==== mop_term_route.sv ====
`timescale 1ns/1ps
`include "mop_defs.svh"
module mop_term_route (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // terminals and codes
  input  wire logic [4:0]  input_terminals,
  input  wire logic [29:0] in_codes,
  input  wire logic [20:0] out_codes,
  input  wire logic        prealarm,
  // routed signals
  output logic             sel_reg,
  output logic             ext_reg,
  output logic      [2:0]  output_terminals
);
  logic       sel_next;
  logic       ext_next;
  logic [2:0] out_next;

  always_comb begin
    sel_next = 1'b0;
    ext_next = 1'b0;
    out_next = 3'b000;
    for (int i = 0; i < 5; i++) begin
      sel_next |= input_terminals[i] && in_codes[i*6 +: 6] == `MOP_FN_SECOND;
      ext_next |= input_terminals[i] && in_codes[i*6 +: 6] == `MOP_FN_OH;
    end
    for (int j = 0; j < 3; j++) begin
      if (out_codes[j*7 +: 7] == `MOP_FN_PRE_POS) begin
        out_next[j] = prealarm;
      end else if (out_codes[j*7 +: 7] == `MOP_FN_PRE_NEG) begin
        out_next[j] = !prealarm;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_reg          <= 1'b0;
      ext_reg          <= 1'b0;
      output_terminals <= 3'b000;
    end else begin
      sel_reg          <= sel_next;
      ext_reg          <= ext_next;
      output_terminals <= out_next;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_neg_pol;
    out_codes[13:7] == `MOP_FN_PRE_NEG |=> output_terminals[1] == !$past(prealarm);
  endproperty
  a_neg_pol: assert property (p_neg_pol) else $error("low-true prealarm wrong");
  property p_oh_route;
    input_terminals[0] && in_codes[5:0] == `MOP_FN_OH |=> ext_reg;
  endproperty
  a_oh_route: assert property (p_oh_route) else $error("relay input not routed");
endmodule // mop_term_route

// ==== mop_top.sv ====
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`include "mop_defs.svh"
module mop_top #(
  parameter int TICK_CYCLES = `MOP_TICK_CYCLES
) (
  // clock and reset
  input  wire logic           core_clk,
  input  wire logic           reset_n,
  // ahb-lite slave
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic      [31:0]    hrdata,
  output logic                hreadyout,
  output logic                hresp,
  // drive measurements
  input  wire logic [15:0]    output_current,
  input  wire logic [15:0]    output_frequency,
  input  wire logic [15:0]    thermistor_resistance,
  input  wire logic [4:0]     input_terminals,
  // protection outputs
  output logic      [2:0]     output_terminals,
  output logic                trip,
  output mop_pkg::mop_fault_e fault_code,
  output logic                thermal_prealarm_indication,
  output logic                analog_freq_cmd_enable
);
  import mop_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic set_ok(input logic [15:0] v, input logic [15:0] lo,
                                  input logic [15:0] hi);
    return v == `MOP_SET_OFF || (v >= lo && v <= hi);
  endfunction

  function automatic logic is_ct(input logic [7:0] code);
    return code == `MOP_CT_A || code == `MOP_CT_B || code == `MOP_CT_C ||
           code == `MOP_CT_D;
  endfunction

  function automatic logic derate_at(input logic ct, input logic [15:0] f);
    return ct ? f < `MOP_CT_MIN_FREQ : f < `MOP_STD_DRT_FREQ;
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [15:0] rated1_reg;
  logic [15:0] rated2_reg;
  logic [15:0] ptc_lvl_reg;
  logic [7:0]  appl_reg;
  logic [7:0]  sec_motor_reg;
  logic [3:0]  swf_reg;
  logic [7:0]  disp_sel_reg;
  logic [29:0] in_codes_reg;
  logic [20:0] out_codes_reg;
  logic [15:0] ptc_disp_reg;
  logic        wr_ph_reg;
  logic        rd_ph_reg;
  logic        rd_done_reg;
  logic [7:0]  addr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rdata_next;
  logic        wr_en;
  logic [31:0] tick_cnt_reg;
  logic        tick;
  logic        sel_reg;
  logic        ext_reg;
  logic        prealarm_reg;
  mop_mode_e   m1;
  mop_mode_e   m2;
  logic        r1z;
  logic        r2z;
  logic        r2off;
  logic        sec;
  logic        ct1;
  logic        ct2;
  logic        ptc_en;
  logic [31:0] acc1;
  logic [31:0] acc2;
  logic [31:0] acct;
  logic        pre1;
  logic        pre2;
  logic        full1;
  logic        full2;
  logic        fullt;
  logic        cause_ptc;
  mop_state_e  state_reg;
  mop_fault_e  fault_reg;
  mop_fault_e  fault_next;

  // ----------------------------------------------------------------
  // ahb-lite slave: writes zero wait, reads one wait
  // ----------------------------------------------------------------
  assign hreadyout = !(rd_ph_reg && !rd_done_reg);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;
  assign wr_en     = wr_ph_reg && hready;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ph_reg <= 1'b0;
      rd_ph_reg <= 1'b0;
      addr_reg  <= 8'h00;
    end else if (hready) begin
      wr_ph_reg <= hsel && htrans[1] && hwrite;
      rd_ph_reg <= hsel && htrans[1] && !hwrite;
      addr_reg  <= haddr[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_done_reg <= 1'b0;
      hrdata_reg  <= 32'h0;
    end else if (rd_ph_reg && !rd_done_reg) begin
      rd_done_reg <= 1'b1;
      hrdata_reg  <= rdata_next;
    end else if (hready) begin
      rd_done_reg <= 1'b0;
    end
  end

  always_comb begin
    rdata_next = 32'h0;
    case (addr_reg)
      `MOP_OFF_RATED1: rdata_next = {16'h0, rated1_reg};
      `MOP_OFF_RATED2: rdata_next = {16'h0, rated2_reg};
      `MOP_OFF_PTC:    rdata_next = {16'h0, ptc_lvl_reg};
      `MOP_OFF_MOTOR:  rdata_next = {disp_sel_reg, 4'h0, swf_reg, sec_motor_reg, appl_reg};
      `MOP_OFF_INSEL:  rdata_next = {2'b00, in_codes_reg};
      `MOP_OFF_OUTSEL: rdata_next = {11'h0, out_codes_reg};
      `MOP_OFF_STATUS: rdata_next = {20'h0, m2, m1, ext_reg, sel_reg, fault_reg,
                                     trip, prealarm_reg};
      `MOP_OFF_PTCRES: rdata_next = {16'h0, ptc_disp_reg};
      `MOP_OFF_ACC1:   rdata_next = acc1;
      `MOP_OFF_ACC2:   rdata_next = acc2;
      `MOP_OFF_ACCT:   rdata_next = acct;
      default:         rdata_next = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rated1_reg <= `MOP_INV_RATED;
    end else if (wr_en && addr_reg == `MOP_OFF_RATED1 && hwdata[15:0] <= `MOP_AMP_MAX) begin
      rated1_reg <= hwdata[15:0];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rated2_reg  <= `MOP_SET_OFF;
      ptc_lvl_reg <= `MOP_SET_OFF;
    end else if (wr_en && disp_sel_reg == 8'h00) begin
      if (addr_reg == `MOP_OFF_RATED2 && set_ok(hwdata[15:0], 16'h0, `MOP_AMP_MAX)) begin
        rated2_reg <= hwdata[15:0];
      end
      if (addr_reg == `MOP_OFF_PTC && set_ok(hwdata[15:0], `MOP_PTC_MIN, `MOP_PTC_MAX)) begin
        ptc_lvl_reg <= hwdata[15:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      appl_reg      <= 8'h00;
      sec_motor_reg <= `MOP_SEL_OFF;
      swf_reg       <= 4'h0;
      disp_sel_reg  <= 8'h00;
    end else if (wr_en && addr_reg == `MOP_OFF_MOTOR) begin
      appl_reg      <= hwdata[`MOP_F_APPL];
      sec_motor_reg <= hwdata[`MOP_F_SEC];
      swf_reg       <= hwdata[`MOP_F_SWF];
      disp_sel_reg  <= hwdata[`MOP_F_DISP];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      in_codes_reg  <= `MOP_IN_CODES_RST;
      out_codes_reg <= `MOP_OUT_CODES_RST;
    end else if (wr_en) begin
      if (addr_reg == `MOP_OFF_INSEL) begin
        in_codes_reg <= hwdata[`MOP_F_INSEL];
      end
      if (addr_reg == `MOP_OFF_OUTSEL) begin
        out_codes_reg <= hwdata[`MOP_F_OUTSEL];
      end
    end
  end

  // ----------------------------------------------------------------
  // integration tick
  // ----------------------------------------------------------------
  assign tick = tick_cnt_reg == 32'(TICK_CYCLES - 1);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_reg <= 32'h0;
    end else begin
      tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // channel modes
  // ----------------------------------------------------------------
  assign r1z   = rated1_reg == 16'h0;
  assign r2z   = rated2_reg == 16'h0;
  assign r2off = rated2_reg == `MOP_SET_OFF;
  assign sec   = sec_motor_reg != `MOP_SEL_OFF;
  assign ct1   = is_ct(appl_reg);
  assign ct2   = sec ? sec_motor_reg == `MOP_CT_A : ct1;

  always_comb begin
    if (r1z) begin
      m1 = MOP_M_OFF;
    end else if (sel_reg && (!r2off || sec)) begin
      m1 = MOP_M_COOL;
    end else begin
      m1 = MOP_M_HEAT;
    end
    if (r2z) begin
      m2 = MOP_M_OFF;
    end else if (r2off && !(sec && !r1z)) begin
      m2 = MOP_M_OFF;
    end else begin
      m2 = sel_reg ? MOP_M_HEAT : MOP_M_COOL;
    end
  end

  mop_thermal_acc u_acc1 (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .tick     (tick),
    .mode     (m1),
    .current  (output_current),
    .rated    (rated1_reg),
    .gain_sh  (4'h0),
    .derate   (derate_at(ct1, output_frequency)),
    .acc_reg  (acc1),
    .pre      (pre1),
    .full     (full1)
  );

  mop_thermal_acc u_acc2 (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .tick     (tick),
    .mode     (m2),
    .current  (output_current),
    .rated    (r2off ? rated1_reg : rated2_reg),
    .gain_sh  (4'h0),
    .derate   (derate_at(ct2, output_frequency)),
    .acc_reg  (acc2),
    .pre      (pre2),
    .full     (full2)
  );

  // output transistors always integrate; switching frequency speeds it up
  mop_thermal_acc u_acct (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .tick     (tick),
    .mode     (MOP_M_HEAT),
    .current  (output_current),
    .rated    (`MOP_INV_RATED),
    .gain_sh  (swf_reg),
    .derate   (1'b0),
    .acc_reg  (acct),
    .pre      (),
    .full     (fullt)
  );

  mop_term_route u_route (
    .core_clk         (core_clk),
    .reset_n          (reset_n),
    .input_terminals  (input_terminals),
    .in_codes         (in_codes_reg),
    .out_codes        (out_codes_reg),
    .prealarm         (prealarm_reg),
    .sel_reg          (sel_reg),
    .ext_reg          (ext_reg),
    .output_terminals (output_terminals)
  );

  // ----------------------------------------------------------------
  // prealarm, thermistor and trip
  // ----------------------------------------------------------------
  assign ptc_en                      = ptc_lvl_reg != `MOP_SET_OFF;
  assign cause_ptc                   = ptc_en && thermistor_resistance >= ptc_lvl_reg;
  assign analog_freq_cmd_enable      = !ptc_en;
  assign thermal_prealarm_indication = prealarm_reg;
  assign trip                        = state_reg == MOP_ST_TRIP;
  assign fault_code                  = fault_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prealarm_reg <= 1'b0;
      ptc_disp_reg <= 16'h0;
    end else begin
      prealarm_reg <= pre1 || pre2;
      ptc_disp_reg <= ptc_en ? thermistor_resistance : 16'h0;
    end
  end

  always_comb begin
    if (full1 || full2) begin
      fault_next = MOP_F_MOTOR;
    end else if (fullt) begin
      fault_next = MOP_F_XTR;
    end else if (ext_reg) begin
      fault_next = MOP_F_EXT;
    end else if (cause_ptc) begin
      fault_next = MOP_F_PTC;
    end else begin
      fault_next = MOP_F_NONE;
    end
  end

  // a trip stays until reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= MOP_ST_RUN;
      fault_reg <= MOP_F_NONE;
    end else begin
      unique case (state_reg)
        MOP_ST_RUN: begin
          if (fault_next != MOP_F_NONE) begin
            state_reg <= MOP_ST_TRIP;
            fault_reg <= fault_next;
          end
        end
        MOP_ST_TRIP: begin
          state_reg <= MOP_ST_TRIP;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_trip_holds;
    trip |=> trip && $stable(fault_code);
  endproperty
  a_trip_holds: assert property (p_trip_holds) else $error("trip released");
  property p_motor_trip;
    !trip && (full1 || full2) |=> trip && fault_code == MOP_F_MOTOR;
  endproperty
  a_motor_trip: assert property (p_motor_trip) else $error("no motor trip");
  property p_pre_no_trip;
    !trip && prealarm_reg && fault_next == MOP_F_NONE |=> !trip;
  endproperty
  a_pre_no_trip: assert property (p_pre_no_trip) else $error("prealarm tripped");
  property p_ext_trip;
    !trip && ext_reg && !full1 && !full2 && !fullt |=> fault_code == MOP_F_EXT;
  endproperty
  a_ext_trip: assert property (p_ext_trip) else $error("no external trip");
  property p_ptc_off;
    !ptc_en |-> !cause_ptc ##1 ptc_disp_reg == 16'h0;
  endproperty
  a_ptc_off: assert property (p_ptc_off) else $error("thermistor not disabled");
  property p_lock;
    wr_en && addr_reg == `MOP_OFF_RATED2 && disp_sel_reg != 8'h00 |=> $stable(rated2_reg);
  endproperty
  a_lock: assert property (p_lock) else $error("locked setting changed");
  property p_second;
    !r2off && !r2z && sel_reg |-> m2 == MOP_M_HEAT && m1 != MOP_M_HEAT;
  endproperty
  a_second: assert property (p_second) else $error("second motor not used");
  property p_read_wait;
    hready && hsel && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read timing wrong");
  property p_pre_level;
    pre1 |=> thermal_prealarm_indication;
  endproperty
  a_pre_level: assert property (p_pre_level) else $error("prealarm missing");
  c_motor_trip: cover property (fault_code == MOP_F_MOTOR);
  c_ext_trip:   cover property (fault_code == MOP_F_EXT);
  c_prealarm:   cover property (!trip && prealarm_reg);
  c_read:       cover property (rd_ph_reg && rd_done_reg);
endmodule // mop_top

// ==== mop_sense_model.sv ====
`timescale 1ns/1ps
module mop_sense_model (
  // bench knobs
  input  wire logic        core_clk,
  input  wire logic [15:0] amps,
  input  wire logic [15:0] ohms,
  input  wire logic        relay_hot,
  input  wire logic        sel_on,
  // sensed values
  output logic      [15:0] output_current,
  output logic      [15:0] thermistor_resistance,
  output logic      [4:0]  input_terminals
);
  logic [2:0] spare_reg = 3'h5;
  // unassigned terminals toggle so no code leans on a settled level
  always @(posedge core_clk) begin
    spare_reg <= ~spare_reg;
    output_current <= amps;
    thermistor_resistance <= ohms;
    input_terminals <= {spare_reg, sel_on, relay_hot};
  end
endmodule // mop_sense_model

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import mop_pkg::*;
  logic core_clk = 1'h0, reset_n = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic relay_hot = 1'h0, sel_on = 1'h0, hreadyout, hresp, trip;
  logic thermal_prealarm_indication, analog_freq_cmd_enable;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_data;
  logic [15:0] amps = 16'h0, ohms = 16'h0, output_frequency = 16'h1388;
  logic [15:0] output_current, thermistor_resistance;
  logic [4:0] input_terminals;
  logic [2:0] output_terminals;
  mop_fault_e fault_code;
  int mismatches = 0, total_checks = 0, cycles = 0;

  mop_top #(.TICK_CYCLES(4)) u_dut (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .output_current(output_current), .output_frequency(output_frequency),
    .thermistor_resistance(thermistor_resistance), .input_terminals(input_terminals),
    .output_terminals(output_terminals), .trip(trip), .fault_code(fault_code),
    .thermal_prealarm_indication(thermal_prealarm_indication),
    .analog_freq_cmd_enable(analog_freq_cmd_enable));
  mop_sense_model u_sense (.core_clk(core_clk), .amps(amps), .ohms(ohms),
    .relay_hot(relay_hot), .sel_on(sel_on), .output_current(output_current),
    .thermistor_resistance(thermistor_resistance), .input_terminals(input_terminals));

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // hready and read data are both taken at the rising edge that ends the phase
  task automatic wait_rdy;
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    rd_data = hrdata;
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(rd_data, exp);
  endtask
  task automatic wait_for(input logic on_trip);
    int n;
    n = 0;
    while ((on_trip ? trip : thermal_prealarm_indication) !== 1'h1 && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task automatic rst;
    reset_n <= 1'h0;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'h1;
    @(posedge core_clk);
  endtask

  initial begin
    rst();
    rd_chk(32'h0, 32'h3e8);
    rd_chk(32'h4, 32'hffff);
    rd_chk(32'h8, 32'hffff);
    rd_chk(32'h1c, 32'h0);
    rd_chk(32'h30, 32'h0);
    chk(hresp, 1'h0);
    bus(1'h1, 32'h0, 32'hc351);
    rd_chk(32'h0, 32'h3e8);
    bus(1'h1, 32'hc, 32'h0100ff00);
    bus(1'h1, 32'h8, 32'h3e8);
    rd_chk(32'h8, 32'hffff);
    bus(1'h1, 32'hc, 32'h0000ff00);
    $display("register test done");
    bus(1'h1, 32'h10, 32'hc7);
    relay_hot <= 1'h1;
    wait_for(1'h1);
    chk({28'h0, fault_code}, {28'h0, MOP_F_EXT});
    relay_hot <= 1'h0;
    repeat (10) @(posedge core_clk);
    chk(trip, 1'h1);
    rst();
    chk(trip, 1'h0);
    $display("relay test done");
    bus(1'h1, 32'h8, 32'h3e8);
    ohms <= 16'h3e7;
    repeat (2) @(posedge core_clk);
    rd_chk(32'h1c, 32'h3e7);
    chk(analog_freq_cmd_enable, 1'h0);
    chk(trip, 1'h0);
    ohms <= 16'h3e8;
    wait_for(1'h1);
    chk({28'h0, fault_code}, {28'h0, MOP_F_PTC});
    rst();
    $display("thermistor test done");
    bus(1'h1, 32'h10, 32'hc7);
    bus(1'h1, 32'h4, 32'h0);
    bus(1'h1, 32'h14, 32'h3608);
    sel_on <= 1'h1;
    bus(1'h1, 32'h0, 32'h64);
    amps <= 16'hc350;
    bus(1'h0, 32'h18, 32'h0);
    chk(rd_data[11:6], 6'h05);
    sel_on <= 1'h0;
    repeat (2) @(posedge core_clk);
    bus(1'h0, 32'h18, 32'h0);
    chk(rd_data[9:8], 2'h3);
    wait_for(1'h0);
    chk(trip, 1'h0);
    repeat (2) @(posedge core_clk);
    chk(output_terminals[1:0], 2'h1);
    wait_for(1'h1);
    chk({28'h0, fault_code}, {28'h0, MOP_F_MOTOR});
    $display("thermal test done");
    print_verdict();
  end
endmodule // testbench
